// ===== bench/irfr_regs_tb_top.sv
// Purpose: self-checking bench of the receive event, mask, irq and fairness registers
// Assumes: one clock; ahb-lite master with single word transfers; hready tied to hreadyout
// Notes:   the master queues expected read data, a negedge monitor pops and compares
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module irfr_regs_tb_top;
    logic        clk, rstn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, exp_v;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  ctx, lf, m, bn, nb;
    logic        summary, want, istart, grant, irq, rd_ph;
    logic [31:0] expq[$];
    int          err_count, n_compared, gcnt;
    logic [7:0]  offs[8] = '{irfr_pkg::OFF_EV_SET, irfr_pkg::OFF_EV_CLR, irfr_pkg::OFF_MASK_SET,
        irfr_pkg::OFF_MASK_CLR, irfr_pkg::OFF_FAIR, irfr_pkg::OFF_IRQ_STAT, irfr_pkg::OFF_IRQ_MASK, 8'h10};

    // single slave, so its ready is the bus ready
    assign hready = hreadyout;

    irfr_regs i_irfr_regs (
        .CLK(clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hreadyout),
        .HRESP(hresp), .RX_CTX_IRQ(ctx), .RX_SUMMARY_INTERRUPT(summary), .PRI_REQ_WANT(want),
        .FAIR_INTERVAL_START(istart), .PRI_REQ_GRANT(grant), .IRQ(irq));

    // 25 MHz clock
    always #20 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // ready is looked at mid-cycle so the edge's own update cannot race the check
    task automatic wait_rdy();
        logic r;
        int   i;
        i = 0;
        do begin
            @(negedge clk);
            r = hreadyout;
            @(posedge clk);
            i++;
        end while (r !== 1'b1 && i < 64);
        if (r !== 1'b1) begin
            err_count++;
            finish_test();
        end
    endtask

    // one transfer; for a read d is the expected word
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= irfr_pkg::HTRANS_NSEQ;
        haddr  <= {24'h000000, a};
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        rd_ph  <= !w;
        if (!w) expq.push_back(d);
        wait_rdy();
        rd_ph  <= 1'b0;
    endtask

    task automatic look(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    // contexts change only just after a rising edge, whatever the caller last waited on
    task automatic pulse(input logic [7:0] v);
        @(posedge clk);
        ctx <= v;
        @(posedge clk);
        ctx <= 8'h00;
        look(4);
    endtask

    // one fairness interval with nw consecutive requests under limit lim
    task automatic fair(input logic [7:0] lim, input int nw);
        xfer(1'b1, irfr_pkg::OFF_FAIR, {lf, lf, lf, lim});
        xfer(1'b0, irfr_pkg::OFF_FAIR, {24'h000000, lim});
        gcnt = 0;
        istart <= 1'b1;
        want   <= 1'b1;
        @(posedge clk);
        istart <= 1'b0;
        repeat (nw - 1) @(posedge clk);
        want <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK("grants", ((lim < nw) ? int'(lim) : nw), gcnt)
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // monitor: read data when the data phase completes, response every cycle out of reset, grants
    always @(negedge clk) begin
        if (rd_ph === 1'b1 && hreadyout === 1'b1) begin
            exp_v = (expq.size() > 0) ? expq.pop_front() : 32'hFFFFFFFF;
            `CHK("read data", exp_v, hrdata)
        end
        if (rstn === 1'b1) `CHK("response", irfr_pkg::HRESP_OKAY, hresp)
        if (grant === 1'b1) gcnt++;
    end

    initial begin
        clk = 0; rstn = 0; hsel = 1; hwrite = 0; haddr = 0; hwdata = 0; htrans = 0;
        hsize = 3'h2; ctx = 0; want = 0; istart = 0; rd_ph = 0; lf = 8'h2E;
        err_count = 0; n_compared = 0; gcnt = 0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        // every register reads zero after reset, an unmapped place too
        foreach (offs[k]) xfer(1'b0, offs[k], 32'h00000000);
        // mask set and clear with random patterns, zeros leave bits alone
        lf = lfsr(lf);
        m = lf;
        xfer(1'b1, irfr_pkg::OFF_MASK_SET, {24'hFFFFFF, m});
        xfer(1'b0, irfr_pkg::OFF_MASK_SET, {24'h000000, m});
        xfer(1'b0, irfr_pkg::OFF_MASK_CLR, {24'h000000, m});
        lf = lfsr(lf);
        xfer(1'b1, irfr_pkg::OFF_MASK_CLR, {24'h000000, lf});
        xfer(1'b1, irfr_pkg::OFF_MASK_SET, 32'h00000000);
        xfer(1'b0, irfr_pkg::OFF_MASK_CLR, {24'h000000, m & ~lf});
        xfer(1'b1, irfr_pkg::OFF_MASK_CLR, 32'h000000FF);
        // a held level must not set again after a clear
        ctx <= 8'h05;
        repeat (2) @(posedge clk);
        xfer(1'b1, irfr_pkg::OFF_EV_CLR, 32'h00000001);
        xfer(1'b1, irfr_pkg::OFF_EV_SET, 32'hFFFFFF80);
        xfer(1'b1, irfr_pkg::OFF_EV_SET, 32'h00000000);
        xfer(1'b1, irfr_pkg::OFF_MASK_CLR, 32'h000000FF);
        xfer(1'b0, irfr_pkg::OFF_EV_CLR, 32'h00000084);
        ctx <= 8'h00;
        xfer(1'b1, irfr_pkg::OFF_EV_CLR, 32'h000000FF);
        // each context alone, its neighbour masked out
        for (int n = 0; n < irfr_pkg::N_CTX; n++) begin
            bn = 8'(1 << n);
            nb = 8'(1 << ((n + 1) % 8));
            xfer(1'b1, irfr_pkg::OFF_MASK_SET, {24'h000000, bn});
            pulse(nb);
            `CHK("summary masked", 1'b0, summary)
            pulse(bn);
            `CHK("summary", 1'b1, summary)
            @(posedge clk);
            xfer(1'b0, irfr_pkg::OFF_EV_SET, {24'h000000, bn | nb});
            xfer(1'b1, irfr_pkg::OFF_EV_CLR, {24'h000000, bn | nb});
            xfer(1'b1, irfr_pkg::OFF_MASK_CLR, {24'h000000, bn});
        end
        // status raised by the summary; mask and clear steer the line
        xfer(1'b0, irfr_pkg::OFF_IRQ_STAT, 32'h00000001);
        // the line is a flop: look mid-cycle, then drive again from an edge
        look(0);
        `CHK("irq masked", 1'b0, irq)
        @(posedge clk);
        xfer(1'b1, irfr_pkg::OFF_IRQ_MASK, 32'h00000003);
        look(1);
        `CHK("irq", 1'b1, irq)
        @(posedge clk);
        xfer(1'b1, irfr_pkg::OFF_IRQ_STAT, 32'h00000001);
        look(1);
        `CHK("irq cleared", 1'b0, irq)
        @(posedge clk);
        // fairness limit: two of four, refusal raises status, none, random
        fair(8'h02, 4);
        xfer(1'b0, irfr_pkg::OFF_IRQ_STAT, 32'h00000002);
        fair(8'h00, 2);
        lf = lfsr(lf);
        fair(lf, 5);
        finish_test();
    end
endmodule
`default_nettype wire

// ===== core/irfr_pkg.sv
// Purpose: shared constants of the receive interrupt and fairness registers
// Assumes: AHB-Lite slave with 32-bit data, byte offsets in the low address bits
// Notes:   every offset, width and reset value of the mapped registers lives here
package irfr_pkg;
    // address decode width and register offsets
    localparam int          ADDR_W       = 8;
    localparam logic [7:0]  OFF_EV_SET   = 8'hA0;
    localparam logic [7:0]  OFF_EV_CLR   = 8'hA4;
    localparam logic [7:0]  OFF_MASK_SET = 8'hA8;
    localparam logic [7:0]  OFF_MASK_CLR = 8'hAC;
    localparam logic [7:0]  OFF_FAIR     = 8'hDC;
    localparam logic [7:0]  OFF_IRQ_STAT = 8'hF0;
    localparam logic [7:0]  OFF_IRQ_MASK = 8'hF4;
    // field sizes
    localparam int          N_CTX        = 8;
    localparam int          FAIR_W       = 8;
    localparam int          IRQ_N        = 2;
    // interrupt status bit positions
    localparam int          IRQ_SUMMARY  = 0;
    localparam int          IRQ_REFUSED  = 1;
    // reset values
    localparam logic [7:0]  EV_RST       = 8'h00;
    localparam logic [7:0]  MASK_RST     = 8'h00;
    localparam logic [7:0]  FAIR_RST     = 8'h00;
    localparam logic [1:0]  IRQ_RST      = 2'h0;
    // bus encodings
    localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
    localparam logic        HRESP_OKAY   = 1'h0;
    localparam logic [31:0] RD_ZERO      = 32'h00000000;
endpackage

// ===== core/irfr_pri_limiter.sv
// Purpose: caps priority arbitration requests per fairness interval
// Assumes: want and interval start come from logic on the same clock
// Notes:   count restarts on interval start, which may coincide with want
`timescale 1ns/100ps
`default_nettype none
module irfr_pri_limiter #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // control
    input  wire logic [W-1:0] limit,
    input  wire logic         want,
    input  wire logic         interval_start,
    // results
    output logic              grant_q,
    output logic              refused_q
);
    logic [W-1:0] cnt_q, cnt_d, base;
    logic         grant_d, refused_d;

    ////////////////////////////////////////////////////////////////
    // grant while the interval count is below the limit; a zero limit refuses all
    always_comb begin
        base      = interval_start ? '0 : cnt_q;
        grant_d   = want && (base < limit);
        refused_d = want && !(base < limit);
        cnt_d     = grant_d ? base + W'(1) : base;
    end

    // registers only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q     <= '0;
            grant_q   <= 1'b0;
            refused_q <= 1'b0;
        end else begin
            cnt_q     <= cnt_d;
            grant_q   <= grant_d;
            refused_q <= refused_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_CAP_HOLDS: assert property (grant_q |-> $past(interval_start) || ($past(cnt_q) < $past(limit)))
        else $error("grant beyond the interval limit");
    // a lowered limit leaves an older count above it until the next interval, so only grants are held to it
    AST_COUNT_LIMIT: assert property (grant_q |-> cnt_q <= $past(limit))
        else $error("interval count passed the limit");
endmodule
`default_nettype wire

// ===== core/irfr_regs.sv
// Purpose: receive context event flags, mask, fairness limit, AHB-Lite slave
// Assumes: context interrupt inputs and fairness strobes are on CLK
// Notes:   reads take one wait state so read data come from a flop
`timescale 1ns/100ps
`default_nettype none
module irfr_regs #(
    parameter int N_CTX  = irfr_pkg::N_CTX,
    parameter int FAIR_W = irfr_pkg::FAIR_W
) (
    // clock and reset
    input  wire logic             CLK,
    input  wire logic             RSTN,
    // ahb-lite slave
    input  wire logic             HSEL,
    input  wire logic [31:0]      HADDR,
    input  wire logic [1:0]       HTRANS,
    input  wire logic             HWRITE,
    input  wire logic [2:0]       HSIZE,
    input  wire logic [31:0]      HWDATA,
    input  wire logic             HREADY,
    output logic      [31:0]      HRDATA,
    output logic                  HREADYOUT,
    output logic                  HRESP,
    // receive contexts
    input  wire logic [N_CTX-1:0] RX_CTX_IRQ,
    output logic                  RX_SUMMARY_INTERRUPT,
    // fairness
    input  wire logic             PRI_REQ_WANT,
    input  wire logic             FAIR_INTERVAL_START,
    output logic                  PRI_REQ_GRANT,
    // interrupt
    output logic                  IRQ
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_RDW  = 2'h2
    } irfr_bus_e;

    localparam int AW = irfr_pkg::ADDR_W;
    localparam int IN = irfr_pkg::IRQ_N;

    // register hit in the captured data-phase address
    function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] off);
        hit = (a == off);
    endfunction

    ////////////////////////////////////////////////////////////////
    // bus state
    irfr_bus_e         st_q, st_d;
    logic [AW-1:0]     addr_q, addr_d;
    logic              wr_q, wr_d;
    logic              rdy_q, rdy_d;
    logic [31:0]       rdata_q, rdata_d;
    logic              resp_q, resp_d;
    logic              acc;

    // register state
    logic [N_CTX-1:0]  ev_q, ev_d;
    logic [N_CTX-1:0]  mask_q, mask_d;
    logic [N_CTX-1:0]  prev_q;
    logic [FAIR_W-1:0] fair_q, fair_d;
    logic [IN-1:0]     stat_q, stat_d;
    logic [IN-1:0]     imask_q, imask_d;
    logic              sum_q, sum_d;
    logic              irq_q, irq_d;
    logic              refused;

    // write strobes of the data phase
    logic              w_ev_set, w_ev_clr, w_m_set, w_m_clr;
    logic              w_fair, w_stat, w_imask;
    logic [N_CTX-1:0]  wd_ctx;
    logic [IN-1:0]     ev_in;

    ////////////////////////////////////////////////////////////////
    // address phase accepted when selected, non-sequential and bus ready
    assign acc = HSEL && (HTRANS == irfr_pkg::HTRANS_NSEQ) && HREADY;

    // bus sequencing: writes commit in their data phase, reads wait one cycle
    // so that a write just before a read is already visible
    always_comb begin
        st_d    = st_q;
        addr_d  = addr_q;
        wr_d    = 1'b0;
        rdy_d   = rdy_q;
        rdata_d = rdata_q;
        resp_d  = irfr_pkg::HRESP_OKAY;   // no transfer is ever answered with an error
        case (st_q)
            ST_IDLE: begin
                rdy_d = 1'b1;
                if (acc) begin
                    addr_d = HADDR[AW-1:0];
                    wr_d   = HWRITE;
                    if (!HWRITE) begin
                        st_d  = ST_RDW;
                        rdy_d = 1'b0;
                    end
                end
            end
            ST_RDW: begin
                st_d  = ST_IDLE;
                rdy_d = 1'b1;
                rdata_d = irfr_pkg::RD_ZERO;
                if (hit(addr_q, irfr_pkg::OFF_EV_SET) || hit(addr_q, irfr_pkg::OFF_EV_CLR)) begin
                    rdata_d[N_CTX-1:0] = ev_q;
                end else if (hit(addr_q, irfr_pkg::OFF_MASK_SET) || hit(addr_q, irfr_pkg::OFF_MASK_CLR)) begin
                    rdata_d[N_CTX-1:0] = mask_q;
                end else if (hit(addr_q, irfr_pkg::OFF_FAIR)) begin
                    rdata_d[FAIR_W-1:0] = fair_q;
                end else if (hit(addr_q, irfr_pkg::OFF_IRQ_STAT)) begin
                    rdata_d[IN-1:0] = stat_q;
                end else if (hit(addr_q, irfr_pkg::OFF_IRQ_MASK)) begin
                    rdata_d[IN-1:0] = imask_q;
                end
            end
            default: begin
                st_d  = ST_IDLE;
                rdy_d = 1'b1;
            end
        endcase
    end

    // bus registers
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_q    <= ST_IDLE;
            addr_q  <= '0;
            wr_q    <= 1'b0;
            rdy_q   <= 1'b1;
            rdata_q <= irfr_pkg::RD_ZERO;
            resp_q  <= irfr_pkg::HRESP_OKAY;
        end else begin
            st_q    <= st_d;
            addr_q  <= addr_d;
            wr_q    <= wr_d;
            rdy_q   <= rdy_d;
            rdata_q <= rdata_d;
            resp_q  <= resp_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // write decode; unmapped writes fall through and change nothing
    always_comb begin
        wd_ctx   = HWDATA[N_CTX-1:0];
        w_ev_set = wr_q && hit(addr_q, irfr_pkg::OFF_EV_SET);
        w_ev_clr = wr_q && hit(addr_q, irfr_pkg::OFF_EV_CLR);
        w_m_set  = wr_q && hit(addr_q, irfr_pkg::OFF_MASK_SET);
        w_m_clr  = wr_q && hit(addr_q, irfr_pkg::OFF_MASK_CLR);
        w_fair   = wr_q && hit(addr_q, irfr_pkg::OFF_FAIR);
        w_stat   = wr_q && hit(addr_q, irfr_pkg::OFF_IRQ_STAT);
        w_imask  = wr_q && hit(addr_q, irfr_pkg::OFF_IRQ_MASK);
    end

    ////////////////////////////////////////////////////////////////
    // event flags: bit N belongs to context N; a set in the same cycle
    // as a clear wins so no context edge is ever lost
    always_comb begin
        ev_d = ev_q;
        if (w_ev_clr) begin
            ev_d = ev_d & ~wd_ctx;
        end
        ev_d = ev_d | (RX_CTX_IRQ & ~prev_q);
        if (w_ev_set) begin
            ev_d = ev_d | wd_ctx;
        end
    end

    // mask: ones written set or clear, zeros leave the bit alone
    always_comb begin
        mask_d = mask_q;
        if (w_m_set) begin
            mask_d = mask_d | wd_ctx;
        end
        if (w_m_clr) begin
            mask_d = mask_d & ~wd_ctx;
        end
    end

    // summary source: any context with both event and enable
    always_comb begin
        sum_d = |(ev_q & mask_q);
    end

    // fairness limit, a plain read-write field
    always_comb begin
        fair_d = fair_q;
        if (w_fair) begin
            fair_d = HWDATA[FAIR_W-1:0];
        end
    end

    // event, mask, summary and fairness registers
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ev_q   <= irfr_pkg::EV_RST;
            mask_q <= irfr_pkg::MASK_RST;
            prev_q <= '0;
            sum_q  <= 1'b0;
            fair_q <= irfr_pkg::FAIR_RST;
        end else begin
            ev_q   <= ev_d;
            mask_q <= mask_d;
            prev_q <= RX_CTX_IRQ;
            sum_q  <= sum_d;
            fair_q <= fair_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // priority request limiter, restarted by each fairness interval
    irfr_pri_limiter #(
        .W              (FAIR_W)
    ) i_irfr_pri_limiter (
        .clk            (CLK),
        .rst_n          (RSTN),
        .limit          (fair_q),
        .want           (PRI_REQ_WANT),
        .interval_start (FAIR_INTERVAL_START),
        .grant_q        (PRI_REQ_GRANT),
        .refused_q      (refused)
    );

    ////////////////////////////////////////////////////////////////
    // sticky interrupt status: summary rise and refused request;
    // write one to clear, a new event in the same cycle wins
    always_comb begin
        ev_in                        = '0;
        ev_in[irfr_pkg::IRQ_SUMMARY] = sum_d && !sum_q;
        ev_in[irfr_pkg::IRQ_REFUSED] = refused;
        stat_d = stat_q;
        if (w_stat) begin
            stat_d = stat_d & ~HWDATA[IN-1:0];
        end
        stat_d  = stat_d | ev_in;
        imask_d = w_imask ? HWDATA[IN-1:0] : imask_q;
        irq_d   = |(stat_q & imask_q);
    end

    // interrupt registers
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            stat_q  <= irfr_pkg::IRQ_RST;
            imask_q <= irfr_pkg::IRQ_RST;
            irq_q   <= 1'b0;
        end else begin
            stat_q  <= stat_d;
            imask_q <= imask_d;
            irq_q   <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs, each from a flop
    assign HRDATA               = rdata_q;
    assign HREADYOUT            = rdy_q;
    assign HRESP                = resp_q;
    assign RX_SUMMARY_INTERRUPT = sum_q;
    assign IRQ                  = irq_q;

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    // read accepted, one wait cycle, then data
    sequence s_rd_acc;
        acc && !HWRITE;
    endsequence
    sequence s_rd_done;
        !HREADYOUT ##1 HREADYOUT;
    endsequence

    AST_READ_WAIT: assert property (s_rd_acc |=> s_rd_done)
        else $error("read did not finish after one wait cycle");
    AST_RSVD_ZERO: assert property (HREADYOUT |-> HRDATA[31:N_CTX] == '0)
        else $error("reserved read bits not zero");
    AST_EDGE_SETS: assert property ($rose(RX_CTX_IRQ[0]) |=> ev_q[0])
        else $error("context 0 edge did not set its flag");
    AST_EDGE_SETS7: assert property ($rose(RX_CTX_IRQ[N_CTX-1]) |=> ev_q[N_CTX-1])
        else $error("context 7 edge did not set its flag");
    AST_CLEAR_ONLY: assert property ($fell(ev_q[0]) |-> $past(w_ev_clr) && $past(HWDATA[0]))
        else $error("event flag cleared without a clear write");
    AST_SUMMARY: assert property (RX_SUMMARY_INTERRUPT == $past(|(ev_q & mask_q)))
        else $error("summary does not follow event and mask");
    AST_MASK_SET: assert property (w_m_set && HWDATA[1] |=> mask_q[1])
        else $error("mask set write ignored");
    AST_MASK_KEEP: assert property (w_m_clr && !HWDATA[2] && !w_m_set |=> mask_q[2] == $past(mask_q[2]))
        else $error("zero at clear address changed mask");
    AST_MASK_READ: assert property (st_q == ST_RDW && (hit(addr_q, irfr_pkg::OFF_MASK_SET)
        || hit(addr_q, irfr_pkg::OFF_MASK_CLR)) |=> HRDATA[N_CTX-1:0] == $past(mask_q))
        else $error("mask read returned wrong value");
    AST_FAIR_WRITE: assert property (w_fair |=> fair_q == $past(HWDATA[FAIR_W-1:0]))
        else $error("fairness write not stored");

    // write accepted; its data phase never waits
    sequence s_wr_acc;
        acc && HWRITE;
    endsequence

    AST_WRITE_NO_WAIT: assert property (s_wr_acc |=> HREADYOUT)
        else $error("write data phase was stretched");
    AST_EV_SET_WRITE: assert property (w_ev_set && wd_ctx[3] |=> ev_q[3])
        else $error("event set write ignored");
    AST_EV_READ: assert property (st_q == ST_RDW && (hit(addr_q, irfr_pkg::OFF_EV_SET)
        || hit(addr_q, irfr_pkg::OFF_EV_CLR)) |=> HRDATA[N_CTX-1:0] == $past(ev_q))
        else $error("event read returned wrong value");
    AST_MASK_CLEAR: assert property (w_m_clr && HWDATA[5] |=> !mask_q[5])
        else $error("mask clear write ignored");
    AST_FAIR_READ: assert property (st_q == ST_RDW && hit(addr_q, irfr_pkg::OFF_FAIR)
        |=> HRDATA == {{(32-FAIR_W){1'b0}}, $past(fair_q)})
        else $error("fairness read returned wrong value");
    AST_REFUSE_FLAG: assert property (refused |=> stat_q[irfr_pkg::IRQ_REFUSED])
        else $error("refused request did not raise its status bit");
    AST_IRQ_LINE: assert property (|(stat_q & imask_q) |=> IRQ)
        else $error("interrupt line low with an enabled status bit");
    // a fresh summary rise in the same cycle keeps the bit, so it is left out here
    AST_STAT_CLEAR: assert property (w_stat && HWDATA[irfr_pkg::IRQ_SUMMARY] && !ev_in[irfr_pkg::IRQ_SUMMARY]
        |=> !stat_q[irfr_pkg::IRQ_SUMMARY])
        else $error("status write of one did not clear");

    // each context edge sets its own flag; only a clear write takes it down,
    // and an enabled flag always reaches the summary a cycle later
    for (genvar g = 0; g < N_CTX; g++) begin : g_ctx_chk
        AST_CTX_EDGE: assert property ($rose(RX_CTX_IRQ[g]) |=> ev_q[g])
            else $error("context edge did not set its flag");
        AST_CTX_HOLD: assert property ($fell(ev_q[g]) |-> $past(w_ev_clr) && $past(wd_ctx[g]))
            else $error("event flag dropped without a clear write");
        AST_CTX_GATE: assert property (ev_q[g] && mask_q[g] |=> RX_SUMMARY_INTERRUPT)
            else $error("enabled context event did not raise the summary");
    end
endmodule
`default_nettype wire
